/* File: logic/pin_sync.v */
`timescale 1ns/10ps
`include "refmode_defines.vh"

module pin_sync #(
	parameter WIDTH = 6
)
(
	input wire hclk,
	input wire hresetn,
	input wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] level_out
);

	// ----------------------------------------------------------------
	// three stages; a change counts once stages two and three agree
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			reg s1_reg;
			reg s2_reg;
			reg s3_reg;
			reg level_reg;
			always @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					level_reg <= 1'b0;
				end
				else
				begin
					s1_reg <= pin_in[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg)
						level_reg <= s3_reg;
				end
			end
			assign level_out[i] = level_reg;
		end
	endgenerate

endmodule

/* File: logic/reference_mode_controller.v */
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "refmode_defines.vh"

module reference_mode_controller
(
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire primary_loss_indication,
	input wire secondary_loss_indication,
	input wire guard_time_input,
	input wire mode_select_low,
	input wire mode_select_high,
	input wire reference_selector,
	output wire secondary_selected,
	output wire holdover_active,
	output wire freerun_active,
	output wire reference_correction_enable,
	output wire tie_correction_enable,
	output wire phase_realign,
	output wire phase_step_active,
	output wire [7:0] phase_step_limit_ns
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	wire [5:0] pins_sync;
	wire los_pri;
	wire los_sec;
	wire guard_expired;
	wire pin_ms_low;
	wire pin_ms_high;
	wire pin_ref_sel;

	pin_sync #(
		.WIDTH(6)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin_in({reference_selector, mode_select_high, mode_select_low,
			guard_time_input, secondary_loss_indication, primary_loss_indication}),
		.level_out(pins_sync)
	);

	assign los_pri = pins_sync[0];
	assign los_sec = pins_sync[1];
	assign guard_expired = pins_sync[2]; // R12
	assign pin_ms_low = pins_sync[3];
	assign pin_ms_high = pins_sync[4];
	assign pin_ref_sel = pins_sync[5];

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	reg [3:0] ctrl_reg;
	reg wr_pend_reg;
	reg [7:0] wr_addr_reg;
	reg [31:0] rdata_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [15:0] offset_reg;
	reg [7:0] step_limit_reg;
	reg [1:0] step_timer_reg;
	reg realign_reg;
	reg tie_latched_reg;

	wire access;
	assign access = hsel && htrans[1] && hready;

	// read data captured in the address phase: a read directly after a
	// write to the same register returns the old value
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg <= `CTRL_RESET;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			rdata_reg <= 32'h00000000;
		end
		else
		begin
			wr_pend_reg <= access && hwrite;
			if (access)
				wr_addr_reg <= haddr;
			if (wr_pend_reg && wr_addr_reg == `CTRL_OFFSET)
				ctrl_reg <= hwdata[3:0];
			if (access && !hwrite)
			begin
				case (haddr)
					`CTRL_OFFSET: rdata_reg <= {28'h0000000, ctrl_reg};
					`STATUS_OFFSET: rdata_reg <= {18'h00000, pins_sync, 4'h0, tie_latched_reg,
						state_reg};
					`PHASE_OFFSET: rdata_reg <= {8'h00, step_limit_reg, offset_reg};
					default: rdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	assign hrdata = rdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ----------------------------------------------------------------
	// mode sources: software override or pins
	// ----------------------------------------------------------------
	wire ms_low;
	wire ms_high;
	wire ref_sel;
	wire auto_mode;

	assign ms_low = ctrl_reg[`CTRL_OVERRIDE_BIT] ? ctrl_reg[`CTRL_MS_LOW_BIT] : pin_ms_low;
	assign ms_high = ctrl_reg[`CTRL_OVERRIDE_BIT] ? ctrl_reg[`CTRL_MS_HIGH_BIT] : pin_ms_high;
	assign ref_sel = ctrl_reg[`CTRL_OVERRIDE_BIT] ? ctrl_reg[`CTRL_REF_SEL_BIT] : pin_ref_sel;
	assign auto_mode = ms_low && ms_high && !ref_sel; // R1

	function is_normal;
		input [2:0] st;
		begin
			is_normal = (st == `ST_PRI_NORMAL) || (st == `ST_SEC_NORMAL);
		end
	endfunction

	function is_hold;
		input [2:0] st;
		begin
			is_hold = (st == `ST_PRI_HOLD) || (st == `ST_SEC_HOLD);
		end
	endfunction

	// ----------------------------------------------------------------
	// state machine
	// ----------------------------------------------------------------
	always @*
	begin
		state_next = state_reg;
		if (auto_mode)
		begin
			case (state_reg)
				`ST_PRI_NORMAL:
					if (los_pri)
						state_next = `ST_PRI_HOLD; // R2 R5
				`ST_PRI_HOLD:
					if (!los_pri)
						state_next = `ST_PRI_NORMAL; // R4 R5
					else if (guard_expired && !los_sec)
						state_next = `ST_SEC_NORMAL; // R3
				`ST_SEC_NORMAL:
					if (!los_pri)
						state_next = `ST_PRI_NORMAL; // R4
					else if (los_sec)
						state_next = `ST_PRI_HOLD;
				default:
					state_next = los_pri ? `ST_PRI_HOLD : `ST_PRI_NORMAL; // R4
			endcase
		end
		else
		begin
			case ({ms_high, ms_low})
				2'b00: state_next = ref_sel ? `ST_SEC_NORMAL : `ST_PRI_NORMAL;
				2'b01: state_next = ref_sel ? `ST_SEC_HOLD : `ST_PRI_HOLD;
				2'b10: state_next = `ST_FREERUN;
				default: state_next = `ST_PRI_HOLD;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state, phase step window and offset tracking
	// ----------------------------------------------------------------
	wire enter_hold;
	wire leave_hold;
	assign enter_hold = is_normal(state_reg) && is_hold(state_next);
	assign leave_hold = is_hold(state_reg) && is_normal(state_next);

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= `ST_PRI_NORMAL;
			offset_reg <= 16'h0000;
			step_limit_reg <= 8'h00;
			step_timer_reg <= 2'h0;
			realign_reg <= 1'b0;
			tie_latched_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			realign_reg <= 1'b0;
			tie_latched_reg <= guard_expired; // R9
			if (enter_hold)
			begin
				step_limit_reg <= `HOLD_STEP_NS; // R6
				step_timer_reg <= `HOLD_STEP_CYC;
			end
			else if (leave_hold)
			begin
				step_limit_reg <= `NORMAL_STEP_NS; // R6
				step_timer_reg <= `NORMAL_STEP_CYC;
				if (tie_latched_reg)
					offset_reg <= offset_reg + {8'h00, `NORMAL_STEP_NS}; // keeps the 200 ns step
				else
				begin
					offset_reg <= 16'h0000; // R7
					realign_reg <= 1'b1; // R7
				end
			end
			else if (step_timer_reg != 2'h0)
				step_timer_reg <= step_timer_reg - 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign secondary_selected = (state_reg == `ST_SEC_NORMAL) || (state_reg == `ST_SEC_HOLD);
	assign holdover_active = is_hold(state_reg);
	assign freerun_active = (state_reg == `ST_FREERUN);
	assign reference_correction_enable = is_normal(state_reg); // R11
	assign tie_correction_enable = tie_latched_reg; // R8
	assign phase_realign = realign_reg;
	assign phase_step_active = (step_timer_reg != 2'h0);
	assign phase_step_limit_ns = step_limit_reg;

endmodule

/* File: pkg/refmode_defines.vh */
// Contract
// R1 - automatic needs both mode selects high, selector low
// R2 - short primary loss: holdover, primary kept
// R3 - guard expired, secondary good: go secondary normal
// R4 - primary recovers: back to primary normal
// R5 - holdover first; early recovery means no switch
// R6 - holdover step 50 ns, return step 200 ns
// R7 - correction off: realign, no accumulated offset
// R8 - brief holdover: controller keeps correction off; here tie_correction_enable just follows the guard input
// R9 - guard level enables correction holdover-to-normal
// R10 - reset held low longer than 300 ns
// R11 - freerun applies no reference correction
// R12 - guard input synchronised; high permits switching
`ifndef REFMODE_DEFINES_VH
`define REFMODE_DEFINES_VH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define PHASE_OFFSET 8'h08
`define CTRL_RESET 4'h0

// ctrl fields
`define CTRL_OVERRIDE_BIT 0
`define CTRL_MS_LOW_BIT 1
`define CTRL_MS_HIGH_BIT 2
`define CTRL_REF_SEL_BIT 3

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
`define ST_PRI_NORMAL 3'h0
`define ST_PRI_HOLD 3'h1
`define ST_SEC_NORMAL 3'h2
`define ST_SEC_HOLD 3'h3
`define ST_FREERUN 3'h4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define HOLD_STEP_NS 8'h32
`define NORMAL_STEP_NS 8'hC8
// step windows in hclk cycles, rounded up from the limits over one period
`define HOLD_STEP_CYC 2'h1
`define NORMAL_STEP_CYC 2'h2

`endif

/* File: test/line_side_model.sv */
`timescale 1ns/10ps
module line_side_model (
	input wire hclk,
	input wire [1:0] ms_cmd,
	input wire pri_loss_cmd,
	input wire sec_loss_cmd,
	input wire guard_cmd,
	output reg primary_loss_indication = 1'b0,
	output reg secondary_loss_indication = 1'b0,
	output reg guard_time_input = 1'b0,
	output reg mode_select_low = 1'b0,
	output reg mode_select_high = 1'b0,
	output wire reference_selector
);
	assign reference_selector = 1'b0;
	always @(posedge hclk)
	begin
		{mode_select_high, mode_select_low} <= ms_cmd;
		primary_loss_indication <= pri_loss_cmd;
		secondary_loss_indication <= sec_loss_cmd;
		// bench keeps guard low for the short outage and the last brief one so correction stays off; the correction case raises it
		guard_time_input <= guard_cmd;
	end
endmodule

/* File: test/refmode_sva.sv */
`timescale 1ns/10ps
module refmode_sva (
	input wire hclk,
	input wire hresetn,
	input wire primary_loss_indication,
	input wire mode_select_low,
	input wire mode_select_high,
	input wire reference_selector,
	input wire secondary_selected,
	input wire holdover_active,
	input wire freerun_active,
	input wire reference_correction_enable,
	input wire tie_correction_enable,
	input wire phase_realign,
	input wire phase_step_active,
	input wire [7:0] phase_step_limit_ns
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire auto_on = mode_select_low && mode_select_high && !reference_selector;
	no_correction_a: assert property (holdover_active || freerun_active |->
		!reference_correction_enable) else $error("correction on");
	hold_step_a: assert property ($rose(holdover_active) &&
		$past(reference_correction_enable) |-> ##[0:2] phase_step_limit_ns == 8'h32)
		else $error("hold step");
	hold_window_a: assert property ($rose(holdover_active) &&
		$past(reference_correction_enable) |-> phase_step_active ##1 !phase_step_active)
		else $error("hold window");
	return_window_a: assert property ($fell(holdover_active) && !freerun_active |->
		phase_step_active [*2] ##1 !phase_step_active) else $error("return window");
	return_step_a: assert property ($fell(holdover_active) && !freerun_active |->
		##[0:2] phase_step_limit_ns == 8'hC8) else $error("return step");
	realign_pulse_a: assert property (phase_realign |=> !phase_realign) else $error("pulse");
	realign_cause_a: assert property ($fell(holdover_active) && !freerun_active &&
		!$past(tie_correction_enable) |-> phase_realign) else $error("no realign");
	guard_gate_a: assert property ($rose(secondary_selected) && auto_on |->
		tie_correction_enable) else $error("early switch");
	primary_kept_a: assert property ($rose(holdover_active) && auto_on &&
		!tie_correction_enable |-> !secondary_selected) else $error("ref lost");
	primary_back_a: assert property ($fell(primary_loss_indication) && auto_on |->
		##[3:7] !holdover_active && !secondary_selected) else $error("no return");
	cover property ($fell(holdover_active) && tie_correction_enable);
	cover property (phase_realign);
	cover property ($rose(secondary_selected));
endmodule
bind reference_mode_controller refmode_sva chk (.hclk, .hresetn, .primary_loss_indication,
	.mode_select_low, .mode_select_high, .reference_selector, .secondary_selected,
	.holdover_active, .freerun_active, .reference_correction_enable,
	.tie_correction_enable, .phase_realign, .phase_step_active, .phase_step_limit_ns);

/* File: test/tb.sv */
`timescale 1ns/10ps
`include "refmode_defines.vh"
module tb;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0, ms_cmd = 2'h3;
	logic [31:0] hwdata = 32'h0, r;
	logic pri_loss_cmd = 0, sec_loss_cmd = 0, guard_cmd = 0;
	wire [2:0] hsize = 3'h2;
	wire [31:0] hrdata;
	wire [7:0] phase_step_limit_ns;
	wire hreadyout, hresp, primary_loss_indication, secondary_loss_indication;
	wire guard_time_input, mode_select_low, mode_select_high, reference_selector;
	wire secondary_selected, holdover_active, freerun_active, reference_correction_enable;
	wire tie_correction_enable, phase_realign, phase_step_active;
	wire hready = hreadyout;
	int checks = 0, n_mismatch = 0, cyc = 0;
	reference_mode_controller dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.primary_loss_indication(primary_loss_indication),
		.secondary_loss_indication(secondary_loss_indication),
		.guard_time_input(guard_time_input),
		.mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
		.reference_selector(reference_selector),
		.secondary_selected(secondary_selected), .holdover_active(holdover_active),
		.freerun_active(freerun_active),
		.reference_correction_enable(reference_correction_enable),
		.tie_correction_enable(tie_correction_enable), .phase_realign(phase_realign),
		.phase_step_active(phase_step_active), .phase_step_limit_ns(phase_step_limit_ns)
	);
	line_side_model lsm (
		.hclk(hclk), .ms_cmd(ms_cmd), .pri_loss_cmd(pri_loss_cmd),
		.sec_loss_cmd(sec_loss_cmd), .guard_cmd(guard_cmd),
		.primary_loss_indication(primary_loss_indication),
		.secondary_loss_indication(secondary_loss_indication),
		.guard_time_input(guard_time_input),
		.mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
		.reference_selector(reference_selector)
	);
	always #50 hclk = ~hclk;
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			report_and_stop;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	// pins need 6 edges to reach the state outputs; 10 leaves margin
	task pins(input logic [1:0] m, input logic l1, input logic l2, input logic g);
		ms_cmd <= m;
		pri_loss_cmd <= l1;
		sec_loss_cmd <= l2;
		guard_cmd <= g;
		repeat (10) @(posedge hclk);
	endtask
	task st(input logic [2:0] s, input logic [2:0] o);
		bus(1'b0, 8'h04, 32'h0);
		chk({r[2:0], holdover_active, secondary_selected, freerun_active, hresp},
			{s, o, 1'b0});
	endtask
	task ph(input logic [15:0] e);
		bus(1'b0, 8'h08, 32'h0);
		chk({16'h0, r[15:0]}, {16'h0, e});
	endtask
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 8'h00, 32'h0);
		chk(r, 32'h0);
		bus(1'b1, 8'h00, 32'h0000000E);
		bus(1'b0, 8'h00, 32'h0);
		chk(r, 32'h0000000E);
		bus(1'b0, 8'h0C, 32'h0);
		chk(r, 32'h0);
		$display("registers done");
		pins(2'h3, 1, 0, 0);
		st(`ST_PRI_HOLD, 3'b100);
		pins(2'h3, 0, 0, 0);
		st(`ST_PRI_NORMAL, 3'b000);
		ph(16'h0000);
		$display("short outage done");
		pins(2'h3, 1, 1, 0);
		pins(2'h3, 1, 1, 1);
		st(`ST_PRI_HOLD, 3'b100);
		pins(2'h3, 1, 0, 1);
		st(`ST_SEC_NORMAL, 3'b010);
		pins(2'h3, 0, 0, 1);
		st(`ST_PRI_NORMAL, 3'b000);
		$display("switch over done");
		pins(2'h3, 1, 1, 1);
		pins(2'h3, 0, 1, 1);
		ph(16'h0190);
		pins(2'h3, 0, 0, 0);
		pins(2'h3, 1, 0, 0);
		pins(2'h3, 0, 0, 0);
		ph(16'h0000);
		$display("correction done");
		pins(2'h2, 0, 0, 0);
		st(`ST_FREERUN, 3'b001);
		chk({31'h0, reference_correction_enable}, 32'h0);
		pins(2'h1, 0, 0, 0);
		st(`ST_PRI_HOLD, 3'b100);
		pins(2'h0, 0, 0, 0);
		st(`ST_PRI_NORMAL, 3'b000);
		bus(1'b1, 8'h00, 32'h00000009);
		st(`ST_SEC_NORMAL, 3'b010);
		bus(1'b1, 8'h00, 32'h0000000B);
		st(`ST_SEC_HOLD, 3'b110);
		bus(1'b1, 8'h00, 32'h00000000);
		st(`ST_PRI_NORMAL, 3'b000);
		ph(16'h0000);
		$display("manual done");
		report_and_stop;
	end
endmodule
